// ===== bench/rtccal_monitor.sv
`timescale 1ns/1ps
module rtccal_monitor
(
    // clock and reset
    input wire CLOCK,
    input wire RST_N,
    // register port
    input wire [7:0] REG_ADDR,
    input wire REG_WR,
    input wire [7:0] REG_WDATA,
    input wire REG_RD,
    input wire [7:0] REG_RDATA,
    input wire REG_RVALID,
    // power
    input wire PRIMARY_POWER_LOST,
    input wire BACKUP_SUPPLY_EN,
    input wire POWER_LOSS_FLAG
);
    wire wk_wr = REG_WR && REG_ADDR == 8'h03;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    rd_late_a: assert property (REG_RD |-> ##2 REG_RVALID)
        else $error("read answer late");
    rd_cause_a: assert property (REG_RVALID |-> $past(REG_RD, 2))
        else $error("read answer unasked");
    rdata_hold_a: assert property (!REG_RVALID |-> $stable(REG_RDATA))
        else $error("read data moved");
    unmapped_zero_a: assert property (REG_RVALID && $past(REG_ADDR, 2) == 8'h02 |-> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    flag_clear_a: assert property (wk_wr && !$rose(PRIMARY_POWER_LOST) |=> !POWER_LOSS_FLAG)
        else $error("flag not cleared");
    bat_write_a: assert property (wk_wr |=> BACKUP_SUPPLY_EN == $past(REG_WDATA[3]))
        else $error("battery enable not written");
    bat_hold_a: assert property (!wk_wr |=> $stable(BACKUP_SUPPLY_EN))
        else $error("battery enable moved");
    flag_set_a: assert property ($rose(PRIMARY_POWER_LOST) && !POWER_LOSS_FLAG |=> POWER_LOSS_FLAG)
        else $error("flag not set");
    flag_sticky_a: assert property (POWER_LOSS_FLAG && !wk_wr |=> POWER_LOSS_FLAG)
        else $error("flag dropped");
    flag_cause_a: assert property ($rose(POWER_LOSS_FLAG) |-> $past(PRIMARY_POWER_LOST) && !$past(PRIMARY_POWER_LOST, 2))
        else $error("flag set without power loss");
endmodule
bind rtccal_regs rtccal_monitor u_mon (.CLOCK(CLOCK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .PRIMARY_POWER_LOST(PRIMARY_POWER_LOST), .BACKUP_SUPPLY_EN(BACKUP_SUPPLY_EN), .POWER_LOSS_FLAG(POWER_LOSS_FLAG));

// ===== bench/rtccal_osc_model.sv
`timescale 1ns/1ps
// crystal stand-in: one tick every four clocks, silent while halted
module rtccal_osc_model
(
    input wire clk,
    input wire halt,
    output reg tick
);
    reg [1:0] cnt = 2'h0;
    initial tick = 1'b0;
    always @(posedge clk)
    begin
        cnt <= cnt + 2'h1;
        tick <= !halt && cnt == 2'h0;
    end
endmodule

// ===== bench/tb_rtccal_regs.sv
`timescale 1ns/1ps
module tb_rtccal_regs;
    reg clock = 1'b0;
    reg rst_n = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg reg_wr = 1'b0;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_rd = 1'b0;
    reg osc_enable = 1'b0;
    reg halt = 1'b0;
    reg day_carry = 1'b0;
    reg [7:0] stamp_minutes = 8'h00;
    reg [7:0] stamp_hours = 8'h13;
    reg power_lost = 1'b0;
    wire [7:0] reg_rdata;
    wire reg_rvalid;
    wire osc_tick;
    wire backup_supply_en;
    wire power_loss_flag;
    integer err_total = 0;
    integer n_compared = 0;
    always #5 clock = ~clock;
    rtccal_osc_model u_rtccal_osc_model (.clk(clock), .halt(halt), .tick(osc_tick));
    rtccal_regs #(.OSC_TIMEOUT_CYC(16'h0010)) u_rtccal_regs (.CLOCK(clock), .RST_N(rst_n),
        .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .OSC_ENABLE(osc_enable), .OSC_TICK(osc_tick),
        .DAY_CARRY(day_carry), .STAMP_MINUTES(stamp_minutes), .STAMP_HOURS(stamp_hours),
        .PRIMARY_POWER_LOST(power_lost), .BACKUP_SUPPLY_EN(backup_supply_en),
        .POWER_LOSS_FLAG(power_loss_flag));
    ////////////////////////////////////////////////////////////////////////////////
    task report_and_stop;
    begin
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    task chk(input [7:0] seen, input [7:0] exp, input string nm);
    begin
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task cyc(input integer n);
    begin
        repeat (n) @(posedge clock);
        #1;
    end
    endtask
    task wr(input [7:0] a, input [7:0] d);
    begin
        cyc(1);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        cyc(1);
        reg_wr = 1'b0;
    end
    endtask
    // bounded wait: a lost answer ends the run as a mismatch
    task rdc(input [7:0] a, input [7:0] exp, input string nm);
        integer i;
    begin
        cyc(1);
        reg_rd = 1'b1;
        reg_addr = a;
        cyc(1);
        reg_rd = 1'b0;
        for (i = 0; i < 4 && reg_rvalid !== 1'b1; i = i + 1)
            cyc(1);
        if (reg_rvalid !== 1'b1)
        begin
            err_total = err_total + 1;
            report_and_stop;
        end
        chk(reg_rdata, exp, nm);
    end
    endtask
    task carry;
    begin
        cyc(1);
        day_carry = 1'b1;
        cyc(1);
        day_carry = 1'b0;
    end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
    begin
        rdc(8'h03, 8'h01, "weekday");
        rdc(8'h04, 8'h01, "date");
        rdc(8'h05, 8'h01, "month");
        rdc(8'h06, 8'h01, "year");
        chk({6'h00, backup_supply_en, power_loss_flag}, 8'h00, "status");
    end
    endtask
    task t_fields;
    begin
        wr(8'h02, 8'h5a);
        rdc(8'h02, 8'h00, "unmapped");
        wr(8'h03, 8'hff);
        rdc(8'h03, 8'h0f, "weekday all ones");
        chk({7'h00, backup_supply_en}, 8'h01, "battery enable");
        wr(8'h03, 8'h07);
        carry;
        rdc(8'h03, 8'h01, "weekday wrap");
        wr(8'h04, 8'hff);
        rdc(8'h04, 8'h3f, "date all ones");
        wr(8'h05, 8'hff);
        rdc(8'h05, 8'h1f, "month all ones");
        wr(8'h06, 8'h24);
        rdc(8'h05, 8'h3f, "month leap");
        rdc(8'h06, 8'h24, "year");
    end
    endtask
    task t_roll(input [7:0] y, input [7:0] m, input [7:0] d, input [7:0] ey, input [7:0] em, input [7:0] ed);
    begin
        wr(8'h06, y);
        wr(8'h05, m);
        wr(8'h04, d);
        carry;
        rdc(8'h06, ey, "year after carry");
        rdc(8'h05, em, "month after carry");
        rdc(8'h04, ed, "date after carry");
    end
    endtask
    task t_power;
    begin
        stamp_minutes = 8'h45;
        power_lost = 1'b1;
        cyc(8);
        chk({7'h00, power_loss_flag}, 8'h01, "flag set");
        rdc(8'h03, 8'h12, "weekday with flag");
        rdc(8'h18, 8'h45, "stamp minutes");
        rdc(8'h19, 8'h13, "stamp hours");
        rdc(8'h1a, 8'h30, "stamp date");
        rdc(8'h1b, 8'h41, "stamp weekday month");
        power_lost = 1'b0;
        cyc(2);
        stamp_minutes = 8'h07;
        power_lost = 1'b1;
        cyc(8);
        rdc(8'h18, 8'h45, "stamp kept");
        wr(8'h03, 8'h10);
        chk({7'h00, power_loss_flag}, 8'h00, "flag cleared");
        cyc(6);
        rdc(8'h18, 8'h00, "stamp zeroed");
        rdc(8'h19, 8'h00, "stamp zeroed");
        rdc(8'h1a, 8'h00, "stamp zeroed");
        rdc(8'h1b, 8'h00, "stamp zeroed");
        power_lost = 1'b0;
    end
    endtask
    task t_osc;
    begin
        wr(8'h03, 8'h02);
        osc_enable = 1'b1;
        cyc(8);
        rdc(8'h03, 8'h22, "osc running");
        halt = 1'b1;
        cyc(24);
        rdc(8'h03, 8'h02, "osc stopped");
        halt = 1'b0;
        cyc(8);
        rdc(8'h03, 8'h22, "osc restarted");
        osc_enable = 1'b0;
        rdc(8'h03, 8'h02, "osc disabled");
    end
    endtask
    // reset again with dirty calendar state
    task t_rerun;
    begin
        cyc(1);
        rst_n = 1'b0;
        cyc(3);
        rst_n = 1'b1;
        t_reset;
    end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(20);
        rst_n = 1'b1;
        t_reset;
        t_fields;
        t_roll(8'h99, 8'h12, 8'h31, 8'h00, 8'h21, 8'h01);
        t_roll(8'h00, 8'h02, 8'h28, 8'h00, 8'h22, 8'h29);
        t_roll(8'h01, 8'h02, 8'h28, 8'h01, 8'h03, 8'h01);
        t_roll(8'h01, 8'h04, 8'h30, 8'h01, 8'h05, 8'h01);
        t_roll(8'h19, 8'h12, 8'h31, 8'h20, 8'h21, 8'h01);
        t_roll(8'h19, 8'h09, 8'h30, 8'h19, 8'h10, 8'h01);
        t_roll(8'h19, 8'h01, 8'h30, 8'h19, 8'h01, 8'h31);
        t_roll(8'h19, 8'h01, 8'h29, 8'h19, 8'h01, 8'h30);
        t_power;
        t_osc;
        t_rerun;
        report_and_stop;
    end
endmodule

// ===== verilog/rtccal_consts.vh
`ifndef RTCCAL_CONSTS_VH
`define RTCCAL_CONSTS_VH

// register offsets
`define RTCCAL_ADDR_HOURS 8'h02
`define RTCCAL_ADDR_DAY_OF_WEEK_FIELD 8'h03
`define RTCCAL_ADDR_DATE 8'h04
`define RTCCAL_ADDR_MONTH 8'h05
`define RTCCAL_ADDR_YEAR 8'h06
// power-fail stamp window: four words from this base
`define RTCCAL_ADDR_STAMP_BASE 8'h18
`define RTCCAL_STAMP_WORDS 4

// weekday register fields
`define RTCCAL_WK_OSC_RUNNING_FLAG_BIT 5
`define RTCCAL_WK_PWRLOSS_BIT 4
`define RTCCAL_WK_BATEN_BIT 3
// month register fields
`define RTCCAL_MTH_LEAP_BIT 5
`define RTCCAL_MTH_TEN_BIT 4

// reset values
`define RTCCAL_RST_DAY_OF_WEEK_FIELD 3'h1
`define RTCCAL_RST_DATE 6'h01
`define RTCCAL_RST_MONTH 5'h01
`define RTCCAL_RST_YEAR 8'h01

// calendar limits
`define RTCCAL_LAST_DAY_OF_WEEK_FIELD 3'h7
`define RTCCAL_LAST_MONTH 5'h12
`define RTCCAL_LAST_YEAR 8'h99

// oscillator watchdog: longest gap between oscillator ticks
// 100 us of the 10 ns clock, sized to the 16-bit watchdog counter
`define RTCCAL_OSC_TIMEOUT_CYC 16'h2710

`endif

// ===== verilog/rtccal_osc_mon.v
`timescale 1ns/1ps
`include "rtccal_consts.vh"

module rtccal_osc_mon
#(
    parameter [15:0] TIMEOUT_CYC = `RTCCAL_OSC_TIMEOUT_CYC
)
(
    // clock and reset
    input wire clk,
    input wire rst_n,
    // oscillator
    input wire osc_enable,
    input wire osc_tick,
    // status
    output reg running
);

reg [15:0] gap;

always @(posedge clk)
begin
    if (!rst_n)
    begin
        gap <= 16'h0000;
        running <= 1'b0;
    end
    else if (!osc_enable)
    begin
        gap <= 16'h0000;
        running <= 1'b0;
    end
    else if (osc_tick)
    begin
        gap <= 16'h0000;
        running <= 1'b1;
    end
    else if (gap >= TIMEOUT_CYC - 16'h0001)
    begin
        // oscillator stalled on its own while still enabled
        running <= 1'b0;
    end
    else
    begin
        gap <= gap + 16'h0001;
    end
end

endmodule

// ===== verilog/rtccal_regs.v
// Functional notes
// - oscillator run bit is read-only, 1 only while enabled and actually running
// - run bit also clears when the oscillator stops by itself
// - power loss loads time-stamp words and sets the sticky power-loss flag
// - clearing the power-loss flag zeroes every time-stamp word
// - no new time-stamp is captured while the flag is still set
// - software can never write the power-loss flag to one
// - a weekday register write clears the power-loss flag, unless a power loss sets it in the same cycle
// - weekday bit 3 is the read/write backup supply enable
// - day of week is a 3-bit field at bits 2-0, values 1 to 7
// - date is BCD, tens digit at bits 5-4, ones at bits 3-0
// - month bit 5 is a read-only leap-year indicator
// - year is two BCD digits, tens at 7-4, ones at 3-0
// - unimplemented upper bits read zero and ignore writes
// - day of week rolls 7 to 1 with no carry
// - past December 31 the date goes to January 1 and year advances
// - year wraps 99 to 00 with no carry
// - February ends on 29 in leap years, 28 otherwise; others fixed
`timescale 1ns/1ps
`include "rtccal_consts.vh"

module rtccal_regs
#(
    parameter [15:0] OSC_TIMEOUT_CYC = `RTCCAL_OSC_TIMEOUT_CYC
)
(
    // clock and reset
    input wire CLOCK,
    input wire RST_N,
    // register port from the serial front end
    input wire [7:0] REG_ADDR,
    input wire REG_WR,
    input wire [7:0] REG_WDATA,
    input wire REG_RD,
    output reg [7:0] REG_RDATA,
    output reg REG_RVALID,
    // timekeeping inputs
    input wire OSC_ENABLE,
    input wire OSC_TICK,
    input wire DAY_CARRY,
    input wire [7:0] STAMP_MINUTES,
    input wire [7:0] STAMP_HOURS,
    // power
    input wire PRIMARY_POWER_LOST,
    output reg BACKUP_SUPPLY_EN,
    output reg POWER_LOSS_FLAG
);

////////////////////////////////////////////////////////////////////////////////

localparam [1:0] ST_IDLE = 2'b00;
localparam [1:0] ST_CAPTURE = 2'b01;
localparam [1:0] ST_ZERO = 2'b10;

function [7:0] bcd_inc;
    input [7:0] v;
    begin
        if (v[3:0] == 4'h9)
        begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end
        else
        begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    end
endfunction

// two-digit BCD year divisible by four
function is_leap;
    input [7:0] y;
    begin
        if (y[4] == 1'b0)
        begin
            is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end
        else
        begin
            is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
    end
endfunction

function [5:0] last_day;
    input [4:0] m;
    input leap;
    begin
        case (m)
            5'h02: last_day = leap ? 6'h29 : 6'h28;
            5'h04, 5'h06, 5'h09, 5'h11: last_day = 6'h30;
            default: last_day = 6'h31;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////

reg [2:0] day_of_week_field;
reg [1:0] date_tens_digit;
reg [3:0] date_ones_digit;
reg month_tens_bit;
reg [3:0] month_ones_digit;
reg [3:0] year_tens_digit;
reg [3:0] year_ones_digit;
reg [1:0] state;
reg [1:0] idx;
reg pwr_lost_d;
reg rd_pend;
reg rd_is_stamp;
reg [7:0] rd_hold;

wire osc_running_flag;
wire [7:0] stamp_rdata;
wire [5:0] date_bcd = {date_tens_digit, date_ones_digit};
wire [4:0] month_bcd = {month_tens_bit, month_ones_digit};
wire [7:0] year_bcd = {year_tens_digit, year_ones_digit};
wire leap_year_flag = is_leap(year_bcd);
wire wr_day_of_week_field = REG_WR && (REG_ADDR == `RTCCAL_ADDR_DAY_OF_WEEK_FIELD);
wire wr_date = REG_WR && (REG_ADDR == `RTCCAL_ADDR_DATE);
wire wr_month = REG_WR && (REG_ADDR == `RTCCAL_ADDR_MONTH);
wire wr_year = REG_WR && (REG_ADDR == `RTCCAL_ADDR_YEAR);
wire loss_event = PRIMARY_POWER_LOST && !pwr_lost_d;
wire capture_start = loss_event && !POWER_LOSS_FLAG;
wire in_stamp = ({REG_ADDR[7:2], 2'b00} == `RTCCAL_ADDR_STAMP_BASE);

////////////////////////////////////////////////////////////////////////////////
// calendar counters

wire end_of_month = (date_bcd == last_day(month_bcd, leap_year_flag));
wire end_of_year = end_of_month && (month_bcd == `RTCCAL_LAST_MONTH);
wire [7:0] date_plus = bcd_inc({2'b00, date_bcd});
wire [7:0] month_plus = bcd_inc({3'b000, month_bcd});
wire [7:0] next_year = (year_bcd == `RTCCAL_LAST_YEAR) ? 8'h00 : bcd_inc(year_bcd);

// a host write to a field wins over a same-cycle day advance of that field
always @(posedge CLOCK)
begin
    if (!RST_N)
    begin
        day_of_week_field <= `RTCCAL_RST_DAY_OF_WEEK_FIELD;
        {date_tens_digit, date_ones_digit} <= `RTCCAL_RST_DATE;
        {month_tens_bit, month_ones_digit} <= `RTCCAL_RST_MONTH;
        {year_tens_digit, year_ones_digit} <= `RTCCAL_RST_YEAR;
        BACKUP_SUPPLY_EN <= 1'b0;
    end
    else
    begin
        if (wr_day_of_week_field)
        begin
            day_of_week_field <= REG_WDATA[2:0];
            BACKUP_SUPPLY_EN <= REG_WDATA[`RTCCAL_WK_BATEN_BIT];
        end
        else if (DAY_CARRY)
        begin
            day_of_week_field <= (day_of_week_field == `RTCCAL_LAST_DAY_OF_WEEK_FIELD) ?
                `RTCCAL_RST_DAY_OF_WEEK_FIELD : day_of_week_field + 3'h1;
        end
        if (wr_date)
        begin
            {date_tens_digit, date_ones_digit} <= REG_WDATA[5:0];
        end
        else if (DAY_CARRY)
        begin
            {date_tens_digit, date_ones_digit} <= end_of_month ? 6'h01 : date_plus[5:0];
        end
        if (wr_month)
        begin
            // leap bit is derived, so bit 5 of the write is dropped
            {month_tens_bit, month_ones_digit} <= REG_WDATA[4:0];
        end
        else if (DAY_CARRY && end_of_month)
        begin
            {month_tens_bit, month_ones_digit} <= end_of_year ? 5'h01 : month_plus[4:0];
        end
        if (wr_year)
        begin
            {year_tens_digit, year_ones_digit} <= REG_WDATA;
        end
        else if (DAY_CARRY && end_of_year)
        begin
            {year_tens_digit, year_ones_digit} <= next_year;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// power-loss flag and time-stamp sequencer

reg stamp_we;
reg [7:0] stamp_wdata;

always @*
begin
    stamp_we = (state != ST_IDLE);
    case (idx)
        2'b00: stamp_wdata = STAMP_MINUTES;
        2'b01: stamp_wdata = STAMP_HOURS;
        2'b10: stamp_wdata = {2'b00, date_bcd};
        default: stamp_wdata = {day_of_week_field, month_bcd};
    endcase
    if (state != ST_CAPTURE)
    begin
        stamp_wdata = 8'h00;
    end
end

always @(posedge CLOCK)
begin
    if (!RST_N)
    begin
        POWER_LOSS_FLAG <= 1'b0;
        pwr_lost_d <= 1'b0;
        state <= ST_IDLE;
        idx <= 2'b00;
    end
    else
    begin
        pwr_lost_d <= PRIMARY_POWER_LOST;
        // set beats the clear of a same-cycle weekday write; written value never sets it
        if (capture_start)
        begin
            POWER_LOSS_FLAG <= 1'b1;
        end
        else if (wr_day_of_week_field)
        begin
            POWER_LOSS_FLAG <= 1'b0;
        end
        // a loss with the flag clear, or a flag clear, restarts the sequence mid-way, so neither event is ever dropped
        if (capture_start)
        begin
            state <= ST_CAPTURE;
            idx <= 2'b00;
        end
        else if (wr_day_of_week_field && POWER_LOSS_FLAG)
        begin
            state <= ST_ZERO;
            idx <= 2'b00;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    idx <= 2'b00;
                end
                ST_CAPTURE, ST_ZERO:
                begin
                    idx <= idx + 2'b01;
                    if (idx == 2'b11)
                    begin
                        state <= ST_IDLE;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
end

rtccal_stamp_mem u_stamp
(
    .clk(CLOCK),
    .wr_en(stamp_we),
    .wr_addr(idx),
    .wr_data(stamp_wdata),
    .rd_addr(REG_ADDR[1:0]),
    .rd_data(stamp_rdata)
);

rtccal_osc_mon #(
    .TIMEOUT_CYC(OSC_TIMEOUT_CYC)
) u_osc
(
    .clk(CLOCK),
    .rst_n(RST_N),
    .osc_enable(OSC_ENABLE),
    .osc_tick(OSC_TICK),
    .running(osc_running_flag)
);

////////////////////////////////////////////////////////////////////////////////
// read path: two-cycle latency so stamp memory and calendar answer alike

always @(posedge CLOCK)
begin
    if (!RST_N)
    begin
        rd_pend <= 1'b0;
        rd_is_stamp <= 1'b0;
        rd_hold <= 8'h00;
        REG_RDATA <= 8'h00;
        REG_RVALID <= 1'b0;
    end
    else
    begin
        rd_pend <= REG_RD;
        rd_is_stamp <= REG_RD && in_stamp;
        if (REG_RD)
        begin
            case (REG_ADDR)
                `RTCCAL_ADDR_DAY_OF_WEEK_FIELD:
                    rd_hold <= {2'b00, osc_running_flag, POWER_LOSS_FLAG, BACKUP_SUPPLY_EN,
                        day_of_week_field};
                `RTCCAL_ADDR_DATE: rd_hold <= {2'b00, date_bcd};
                `RTCCAL_ADDR_MONTH: rd_hold <= {2'b00, leap_year_flag, month_bcd};
                `RTCCAL_ADDR_YEAR: rd_hold <= year_bcd;
                default: rd_hold <= 8'h00;
            endcase
        end
        REG_RVALID <= rd_pend;
        if (rd_pend)
        begin
            REG_RDATA <= rd_is_stamp ? stamp_rdata : rd_hold;
        end
    end
end

endmodule

// ===== verilog/rtccal_stamp_mem.v
`timescale 1ns/1ps
`include "rtccal_consts.vh"

module rtccal_stamp_mem
(
    // clock
    input wire clk,
    // write port
    input wire wr_en,
    input wire [1:0] wr_addr,
    input wire [7:0] wr_data,
    // read port
    input wire [1:0] rd_addr,
    output reg [7:0] rd_data
);

reg [7:0] mem [0:`RTCCAL_STAMP_WORDS-1];

always @(posedge clk)
begin
    if (wr_en)
    begin
        mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
end

endmodule
